/* verilog/hvpp_cfg.svh */
`ifndef HVPP_CFG_SVH
`define HVPP_CFG_SVH

// ***************************************************************
// Timing
// ***************************************************************
`define HVPP_CLK_PERIOD_NS 10
`define HVPP_ENTRY_HOLD_NS 10000
`define HVPP_ENTRY_CYCLES ((`HVPP_ENTRY_HOLD_NS + `HVPP_CLK_PERIOD_NS - 1) / `HVPP_CLK_PERIOD_NS)

// ***************************************************************
// Load strobe action codes {bit1, bit0}
// ***************************************************************
`define HVPP_ACT_ADDR 2'h0
`define HVPP_ACT_DATA 2'h1
`define HVPP_ACT_CMD 2'h2
`define HVPP_ACT_IDLE 2'h3

// ***************************************************************
// Command bytes
// ***************************************************************
`define HVPP_CMD_NOP 8'h00
`define HVPP_CMD_ERASE 8'h80
`define HVPP_CMD_WR_FUSE 8'h40
`define HVPP_CMD_WR_LOCK 8'h20
`define HVPP_CMD_WR_FLASH 8'h10
`define HVPP_CMD_WR_EEPROM 8'h11
`define HVPP_CMD_RD_SIG 8'h08
`define HVPP_CMD_RD_FUSE 8'h04
`define HVPP_CMD_RD_FLASH 8'h02
`define HVPP_CMD_RD_EEPROM 8'h03

// ***************************************************************
// Page layout, reset values, buffer
// ***************************************************************
`define HVPP_WORD_BITS 6
`define HVPP_PAGE_BITS 8
`define HVPP_CMD_RST 8'h00
`define HVPP_BYTE_RST 8'h00
`define HVPP_BUF_DEPTH 16

`endif

/* verilog/hvpp_pkg.sv */
package hvpp_pkg;
  typedef enum logic [2:0] {
    HVPP_IDLE,
    HVPP_ERASE_MEM,
    HVPP_ERASE_LOCK,
    HVPP_WRITE
  } hvpp_state_t;

  typedef enum logic [2:0] {
    HVPP_OP_NONE,
    HVPP_OP_FLASH,
    HVPP_OP_EEPROM,
    HVPP_OP_FUSE,
    HVPP_OP_LOCK
  } hvpp_op_t;
endpackage

/* verilog/hvpp_port.sv */
`timescale 1ns/1ps
`include "hvpp_cfg.svh"
// Function
// - Strobe with action 00 loads address byte; 10 loads command; 11 idles.
// - Strobe with action 01 loads data byte, low or high by byte select one.
// - Write pulse runs stored command: erase, write fuse, write lock.
// - Command 0x10 is write Flash, 0x11 is write EEPROM.
// - Commands 0x08, 0x04, 0x02, 0x03 are the four read commands.
// - Ready/busy is low during erase or programming, high when ready.
// - Data bus is driven only while output enable is low.
// - Byte select one picks low or high byte for loads and reads.
// - Byte select two picks low or extended high byte where used.
// - Page latch pulse moves loaded data word into page buffer.
// - Entry pins held 0000 for 10 us after reset release enter mode.
// - Reset pin low ends programming mode.
// - Command and address persist across many operations.
// - Erase clears Flash, EEPROM, then locks only after memory erase completes.
// - Keep-EEPROM fuse programmed means erase leaves EEPROM untouched.
// - Write pulse after erase command starts erase and drops ready/busy.
// - Flash programmed page at a time through page buffer, 256 pages.
// - Low address bits select word in page, higher bits select page.

// ***************************************************************
// Page buffer FIFO
// ***************************************************************
module hvpp_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_ptr_q];
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      in_ready_o <= (cnt_d != (AW+1)'(DEPTH));
      out_valid_o <= (cnt_d != '0);
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
  // Storage carries no reset; only valid entries are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end
endmodule
// ***************************************************************
// Programming port
// ***************************************************************
module hvpp_port (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic load_strobe_i,
  input wire logic strobe_action_bit0_i,
  input wire logic strobe_action_bit1_i,
  input wire logic byte_select_one_i,
  input wire logic byte_select_two_i,
  input wire logic page_latch_strobe_i,
  input wire logic wr_b_i,
  input wire logic oe_b_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic ready_not_busy_o,
  output logic prog_mode_o,
  input wire logic keep_eeprom_on_erase_fuse_b_i,
  output logic [7:0] cmd_o,
  output logic [15:0] addr_o,
  output logic [7:0] data_lo_o,
  output logic byte_sel_one_o,
  output logic byte_sel_two_o,
  input wire logic [7:0] rd_byte_i,
  output logic erase_flash_o,
  output logic erase_eeprom_o,
  output logic clear_lock_o,
  output logic op_start_o,
  output hvpp_pkg::hvpp_op_t op_o,
  input wire logic mem_done_i,
  output logic buf_valid_o,
  input wire logic buf_ready_i,
  output logic [`HVPP_WORD_BITS-1:0] word_in_page_bits_o,
  output logic [15:0] buf_word_o
);
  import hvpp_pkg::*;
  localparam int NPIN = 17;
  localparam int ENTRY_CYC = `HVPP_ENTRY_CYCLES;
  localparam int FW = `HVPP_WORD_BITS + 16;
  // ***************************************************************
  // Pin synchronisers and edge detect
  // ***************************************************************
  logic [NPIN-1:0] meta_q;
  logic [NPIN-1:0] sync_q;
  logic [NPIN-1:0] prev_q;
  logic [NPIN-1:0] pins;
  assign pins = {keep_eeprom_on_erase_fuse_b_i, data_i, oe_b_i, wr_b_i, page_latch_strobe_i,
                 byte_select_two_i, byte_select_one_i, strobe_action_bit1_i, strobe_action_bit0_i,
                 load_strobe_i};
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  logic ls_rise;
  logic pl_rise;
  logic wr_fall;
  logic [1:0] act;
  logic bs1;
  logic bs2;
  logic oe_b;
  logic [7:0] din;
  logic keep_ee_b;
  assign ls_rise = sync_q[0] && !prev_q[0];
  assign act = sync_q[2:1];
  assign bs1 = sync_q[3];
  assign bs2 = sync_q[4];
  assign pl_rise = sync_q[5] && !prev_q[5];
  assign wr_fall = !sync_q[6] && prev_q[6];
  assign oe_b = sync_q[7];
  assign din = sync_q[15:8];
  assign keep_ee_b = sync_q[16];
  logic [10:0] entry_cnt_q;
  logic entry_done_q;
  logic entry_bad_q;
  // Entry pattern: page latch, both action bits and byte select one low for the hold time
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      entry_cnt_q <= '0;
      entry_done_q <= 1'b0;
      entry_bad_q <= 1'b0;
      prog_mode_o <= 1'b0;
    end else if (!entry_done_q) begin
      if (sync_q[5] || sync_q[2] || sync_q[1] || sync_q[3]) begin
        entry_bad_q <= 1'b1;
      end
      if (entry_cnt_q == 11'(ENTRY_CYC - 1)) begin
        entry_done_q <= 1'b1;
        prog_mode_o <= !entry_bad_q && !(sync_q[5] || sync_q[2] || sync_q[1] || sync_q[3]);
      end else begin
        entry_cnt_q <= entry_cnt_q + 11'h001;
      end
    end
  end

  // ***************************************************************
  // Load strobe decode
  // ***************************************************************
  logic [7:0] data_hi_q;
  // Loads are kept until overwritten, so one command serves many accesses
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_o <= `HVPP_CMD_RST;
      addr_o <= '0;
      data_lo_o <= `HVPP_BYTE_RST;
      data_hi_q <= `HVPP_BYTE_RST;
    end else if (prog_mode_o && ls_rise) begin
      unique case (act)
        `HVPP_ACT_ADDR: begin
          if (bs1) begin
            addr_o[15:8] <= din;
          end else begin
            addr_o[7:0] <= din;
          end
        end
        `HVPP_ACT_DATA: begin
          if (bs1) begin
            data_hi_q <= din;
          end else begin
            data_lo_o <= din;
          end
        end
        `HVPP_ACT_CMD: cmd_o <= din;
        `HVPP_ACT_IDLE: ;
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_oe_o <= 1'b0;
      data_o <= `HVPP_BYTE_RST;
      byte_sel_one_o <= 1'b0;
      byte_sel_two_o <= 1'b0;
    end else begin
      data_oe_o <= prog_mode_o && !oe_b;
      data_o <= rd_byte_i;
      byte_sel_one_o <= bs1;
      byte_sel_two_o <= bs2;
    end
  end

  // ***************************************************************
  // Page buffer fill
  // ***************************************************************
  logic buf_in_ready;
  logic buf_push;
  logic [FW-1:0] buf_out;
  assign buf_push = prog_mode_o && pl_rise;
  hvpp_fifo #(
    .WIDTH(FW),
    .DEPTH(`HVPP_BUF_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(buf_push),
    .in_ready_o(buf_in_ready),
    .in_data_i({addr_o[`HVPP_WORD_BITS-1:0], data_hi_q, data_lo_o}),
    .out_valid_o(buf_valid_o),
    .out_ready_i(buf_ready_i),
    .out_data_o(buf_out)
  );
  assign word_in_page_bits_o = buf_out[FW-1:16];
  assign buf_word_o = buf_out[15:0];
  // ***************************************************************
  // Write and erase sequencer
  // ***************************************************************
  hvpp_state_t state_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= HVPP_IDLE;
      op_start_o <= 1'b0;
      op_o <= HVPP_OP_NONE;
      erase_flash_o <= 1'b0;
      erase_eeprom_o <= 1'b0;
      clear_lock_o <= 1'b0;
    end else begin
      op_start_o <= 1'b0;
      erase_flash_o <= 1'b0;
      erase_eeprom_o <= 1'b0;
      clear_lock_o <= 1'b0;
      unique case (state_q)
        HVPP_IDLE: begin
          if (prog_mode_o && wr_fall) begin
            unique case (cmd_o)
              `HVPP_CMD_ERASE: begin
                state_q <= HVPP_ERASE_MEM;
                erase_flash_o <= 1'b1;
                erase_eeprom_o <= keep_ee_b;
              end
              `HVPP_CMD_WR_FUSE, `HVPP_CMD_WR_LOCK, `HVPP_CMD_WR_FLASH, `HVPP_CMD_WR_EEPROM: begin
                state_q <= HVPP_WRITE;
                op_start_o <= 1'b1;
                op_o <= (cmd_o == `HVPP_CMD_WR_FUSE) ? HVPP_OP_FUSE :
                        (cmd_o == `HVPP_CMD_WR_LOCK) ? HVPP_OP_LOCK :
                        (cmd_o == `HVPP_CMD_WR_FLASH) ? HVPP_OP_FLASH : HVPP_OP_EEPROM;
              end
              // Reads act on output enable only; a write pulse does nothing
              default: ;
            endcase
          end
        end
        HVPP_ERASE_MEM: begin
          if (mem_done_i) begin
            state_q <= HVPP_ERASE_LOCK;
            clear_lock_o <= 1'b1;
          end
        end
        HVPP_ERASE_LOCK: state_q <= HVPP_IDLE;
        HVPP_WRITE: begin
          if (mem_done_i) begin
            state_q <= HVPP_IDLE;
          end
        end
        default: state_q <= HVPP_IDLE;
      endcase
    end
  end
  // Busy also while the buffer is full, so the programmer stalls its latches
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready_not_busy_o <= 1'b1;
    end else begin
      ready_not_busy_o <= (state_q == HVPP_IDLE) && !(prog_mode_o && wr_fall) && buf_in_ready;
    end
  end
  // ***************************************************************
  // Checks
  // ***************************************************************
  AST_OE_DRIVE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    data_oe_o |-> $past(!oe_b && prog_mode_o)) else $error("bus driven without output enable");
  AST_CMD_LOAD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (prog_mode_o && ls_rise && act == `HVPP_ACT_CMD) |=> cmd_o == $past(din)) else $error("command not loaded");
  AST_IDLE_ACT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ls_rise && act == `HVPP_ACT_IDLE) |=> $stable(cmd_o) && $stable(addr_o)) else $error("idle action changed state");
  AST_DATA_HI: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (prog_mode_o && ls_rise && act == `HVPP_ACT_DATA && bs1) |=> data_hi_q == $past(din) && $stable(data_lo_o))
    else $error("high data byte not loaded");
  AST_ADDR_LO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (prog_mode_o && ls_rise && act == `HVPP_ACT_ADDR && !bs1) |=> addr_o[7:0] == $past(din) && $stable(addr_o[15:8]))
    else $error("low address byte not loaded");
  AST_ERASE_BUSY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_q == HVPP_IDLE && prog_mode_o && wr_fall && cmd_o == `HVPP_CMD_ERASE) |=> !ready_not_busy_o ##1 !ready_not_busy_o)
    else $error("erase did not drop ready");
  AST_LOCK_AFTER: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    clear_lock_o |-> $past(state_q == HVPP_ERASE_MEM && mem_done_i)) else $error("locks cleared early");
  AST_KEEP_EE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    erase_eeprom_o |-> $past(keep_ee_b)) else $error("EEPROM erased while kept");
  AST_BUSY_WRITE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_q == HVPP_WRITE) |=> !ready_not_busy_o) else $error("ready during write");
  AST_PAGE_PUSH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (buf_push && buf_in_ready && !buf_valid_o) |=> buf_valid_o ##0 buf_word_o == $past({data_hi_q, data_lo_o}))
    else $error("page latch lost word");
endmodule

/* sim/hvpp_backend_model.sv */
`timescale 1ns/1ps
// ***************************************************************
// Memory backend model
// ***************************************************************
module hvpp_backend_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic erase_flash_i,
  input wire logic erase_eeprom_i,
  input wire logic clear_lock_i,
  input wire logic op_start_i,
  input wire logic [15:0] addr_i,
  input wire logic byte_sel_one_i,
  input wire logic byte_sel_two_i,
  input wire logic stall_i,
  output logic [7:0] rd_byte_o,
  output logic mem_done_o,
  output logic buf_ready_o,
  output logic [7:0] ee_cnt_o,
  output logic [7:0] lock_cnt_o
);
  logic [7:0] wait_q;
  logic busy_q;
  // Read byte depends on address and selects only, so the bench can predict it
  assign rd_byte_o = addr_i[7:0] ^ {6'h00, byte_sel_two_i, byte_sel_one_i} ^ 8'h5A;
  // Bench stalls the page drain to exercise back-pressure
  assign buf_ready_o = !stall_i;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_q <= 8'h00;
      busy_q <= 1'b0;
      mem_done_o <= 1'b0;
    end else begin
      mem_done_o <= 1'b0;
      if (erase_flash_i || op_start_i) begin
        busy_q <= 1'b1;
        // Both outlast a write pulse so busy can be seen before completion
        wait_q <= erase_flash_i ? 8'h3C : 8'h28;
      end else if (busy_q && wait_q == 8'h00) begin
        busy_q <= 1'b0;
        mem_done_o <= 1'b1;
      end else if (busy_q) begin
        wait_q <= wait_q - 8'h01;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ee_cnt_o <= 8'h00;
      lock_cnt_o <= 8'h00;
    end else begin
      ee_cnt_o <= ee_cnt_o + 8'(erase_eeprom_i);
      lock_cnt_o <= lock_cnt_o + 8'(clear_lock_i);
    end
  end
endmodule

/* sim/hvpp_port_bench.sv */
`timescale 1ns/1ps
`include "hvpp_cfg.svh"
module hvpp_port_bench;
  import hvpp_pkg::*;
  logic clk, rst_b, strobe, latch, wr_b, oe_b, sel1, sel2, fuse_b, stall;
  logic [1:0] act;
  logic [7:0] din, dout, cmd, dlo, rd_byte, ee_cnt, lk_cnt;
  logic [15:0] addr, buf_word;
  logic [5:0] wip;
  logic doe, ready, pmode, bs1o, bs2o, er_f, er_e, clr, start, done, bvalid, bready;
  hvpp_op_t op;
  int bad_count, num_checks;
  logic [7:0] cmds [9] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h11, 8'h08, 8'h04, 8'h02, 8'h03};
  logic [7:0] wcmd [4] = '{8'h10, 8'h11, 8'h40, 8'h20};
  hvpp_op_t wop [4] = '{HVPP_OP_FLASH, HVPP_OP_EEPROM, HVPP_OP_FUSE, HVPP_OP_LOCK};

  hvpp_port dut_u (.clk_i(clk), .rst_b_i(rst_b), .load_strobe_i(strobe), .strobe_action_bit0_i(act[0]),
    .strobe_action_bit1_i(act[1]), .byte_select_one_i(sel1), .byte_select_two_i(sel2),
    .page_latch_strobe_i(latch), .wr_b_i(wr_b), .oe_b_i(oe_b), .data_i(din), .data_o(dout),
    .data_oe_o(doe), .ready_not_busy_o(ready), .prog_mode_o(pmode), .keep_eeprom_on_erase_fuse_b_i(fuse_b),
    .cmd_o(cmd), .addr_o(addr), .data_lo_o(dlo), .byte_sel_one_o(bs1o), .byte_sel_two_o(bs2o),
    .rd_byte_i(rd_byte), .erase_flash_o(er_f), .erase_eeprom_o(er_e), .clear_lock_o(clr),
    .op_start_o(start), .op_o(op), .mem_done_i(done), .buf_valid_o(bvalid), .buf_ready_i(bready),
    .word_in_page_bits_o(wip), .buf_word_o(buf_word));

  hvpp_backend_model far_u (.clk_i(clk), .rst_b_i(rst_b), .erase_flash_i(er_f), .erase_eeprom_i(er_e),
    .clear_lock_i(clr), .op_start_i(start), .addr_i(addr), .byte_sel_one_i(bs1o), .byte_sel_two_i(bs2o),
    .stall_i(stall), .rd_byte_o(rd_byte), .mem_done_o(done), .buf_ready_o(bready), .ee_cnt_o(ee_cnt),
    .lock_cnt_o(lk_cnt));

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Every pulse is 30 cycles wide, above the minimum width
  task automatic load(input logic [1:0] a, input logic s1, input logic [7:0] d);
    @(posedge clk);
    act <= a;
    sel1 <= s1;
    din <= d;
    ticks(10);
    strobe <= 1'b1;
    ticks(30);
    strobe <= 1'b0;
    ticks(30);
  endtask
  task automatic write_pulse();
    @(posedge clk);
    wr_b <= 1'b0;
    ticks(30);
    wr_b <= 1'b1;
    @(negedge clk);
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk("ready", 16'h1, 16'(ready));
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ***************************************************************
  // Clock, watchdog and test sequence
  // ***************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #600000;
    bad_count++;
    $display("mismatch watchdog expected done seen hang");
    close_out();
  end
  initial begin
    int n;
    {rst_b, strobe, latch, sel1, sel2, act, din} = '0;
    {wr_b, oe_b, fuse_b, stall} = 4'hF;
    bad_count = 0;
    num_checks = 0;
    @(negedge clk);
    chk("ready", 16'h1, 16'(ready));
    chk("cmd", 16'h0, 16'(cmd));
    ticks(3);
    rst_b <= 1'b1;
    ticks(990);
    @(negedge clk);
    chk("mode", 16'h0, 16'(pmode));
    n = 0;
    while (pmode !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("mode", 16'h1, 16'(pmode));
    ticks(30000);
    foreach (cmds[i]) begin
      load(`HVPP_ACT_CMD, 1'b0, cmds[i]);
      chk("cmd", 16'(cmds[i]), 16'(cmd));
    end
    load(`HVPP_ACT_IDLE, 1'b0, 8'h55);
    chk("cmd", 16'h0003, 16'(cmd));
    load(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_RD_FLASH);
    load(`HVPP_ACT_ADDR, 1'b1, 8'h12);
    load(`HVPP_ACT_ADDR, 1'b0, 8'hC5);
    chk("addr", 16'h12C5, addr);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      sel1 <= k[0];
      sel2 <= k[1];
      oe_b <= 1'b0;
      ticks(10);
      @(negedge clk);
      chk("drive", 16'h1, 16'(doe));
      chk("sel", 16'(k), 16'({bs2o, bs1o}));
      chk("rdata", 16'(8'h9F ^ 8'(k)), 16'(dout));
      @(posedge clk);
      oe_b <= 1'b1;
      ticks(10);
      @(negedge clk);
      chk("drive", 16'h0, 16'(doe));
    end
    chk("cmd", 16'h0002, 16'(cmd));
    load(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_WR_FLASH);
    // Only the low address byte is reloaded: the whole page sits in one 256-word window
    for (int w = 3; w < 3 + `HVPP_BUF_DEPTH; w++) begin
      load(`HVPP_ACT_ADDR, 1'b0, 8'h40 | 8'(w));
      load(`HVPP_ACT_DATA, 1'b0, 8'(w));
      chk("data_lo", 16'(w), 16'(dlo));
      load(`HVPP_ACT_DATA, 1'b1, 8'hA0 ^ 8'(w));
      @(posedge clk);
      latch <= 1'b1;
      ticks(30);
      latch <= 1'b0;
      ticks(30);
      chk("word_idx", 16'h3, 16'(wip));
      chk("word", 16'hA303, buf_word);
    end
    @(negedge clk);
    chk("ready_full", 16'h0, 16'(ready));
    @(posedge clk);
    stall <= 1'b0;
    @(negedge clk);
    n = 0;
    // One word leaves per cycle once the drain runs; each must come out in latch order
    while (bvalid === 1'b1 && n < 100) begin
      chk("drain_idx", 16'(3 + n), 16'(wip));
      chk("drain_word", {8'hA0 ^ 8'(3 + n), 8'(3 + n)}, buf_word);
      @(negedge clk);
      n++;
    end
    chk("drained", 16'h0, 16'(bvalid));
    chk("drain_count", 16'(`HVPP_BUF_DEPTH), 16'(n));
    wait_ready();
    foreach (wcmd[i]) begin
      load(`HVPP_ACT_CMD, 1'b0, wcmd[i]);
      write_pulse();
      chk("busy", 16'h0, 16'(ready));
      chk("op", 16'(wop[i]), 16'(op));
      wait_ready();
    end
    // Erases close the run: erased cells read all ones, so nothing is written afterwards
    for (int f = 0; f < 2; f++) begin
      @(posedge clk);
      fuse_b <= f[0];
      load(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_ERASE);
      write_pulse();
      chk("busy", 16'h0, 16'(ready));
      chk("lock_early", 16'(f), 16'(lk_cnt));
      wait_ready();
      chk("lock_clear", 16'(f + 1), 16'(lk_cnt));
      chk("ee_erase", 16'(f), 16'(ee_cnt));
    end
    @(posedge clk);
    rst_b <= 1'b0;
    @(negedge clk);
    chk("mode", 16'h0, 16'(pmode));
    close_out();
  end
endmodule
